//--- src/hmb_top.sv
//----------------------------------------------------------------------
// Purpose: Mailbox between a host bus and the local processor
// Assumes: Host strobes are asynchronous and held several clocks
// Notes:   Local bus strobes are single cycle on clk_sys
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module hmb_top
    import hmb_pkg::*;
(
    input wire logic clk_sys, // System clock, 20 MHz
    input wire logic srst, // Board reset, active high
    input wire hmb_lreq_t lreq, // Local processor request
    output logic [7:0] local_rdata, // Local read data, next cycle
    output logic local_irq, // Local interrupt request level
    input wire logic host_rd, // Host port read strobe, async
    input wire logic host_wr, // Host port write strobe, async
    input wire logic host_inta, // Host interrupt acknowledge, async
    input wire logic host_addr, // Host port offset, async
    input wire logic [7:0] host_wdata, // Host write data, async
    output logic [7:0] host_rdata, // Host read data
    input wire logic host_interrupt_line_i, // Interrupt line level
    output logic host_interrupt_line_o, // Interrupt line drive value
    output logic host_interrupt_line_oe_n, // Low while driving line
    output logic tx_enable, // Line transmitter enable
    output logic par_irq_enable, // Parallel port interrupt enable
    output logic core_reset // Internal reset line, active high
);

    // -----------------------------------------------------------------
    // Host pin synchronisation
    // -----------------------------------------------------------------
    logic [HOST_SYNC_W-1:0] host_sync;
    logic hs_rd;
    logic hs_wr;
    logic hs_ack;
    logic hs_addr;
    logic [7:0] hs_wdata;

    hmb_sync #(.W(HOST_SYNC_W)) u_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .d_async({host_rd, host_wr, host_inta, host_addr, host_wdata}),
        .q_sync(host_sync)
    );

    assign {hs_rd, hs_wr, hs_ack, hs_addr, hs_wdata} = host_sync;

    hmb_state_t s_reg;
    hmb_state_t s_next;
    logic int_rst;
    logic h_rd_ev;
    logic h_wr_ev;
    logic h_ack_ev;
    logic swrst_hit;
    logic cmd_wr_ev;

    // Rising edges of host strobes become single cycle events
    assign h_rd_ev = hs_rd & ~s_reg.rd_q;
    assign h_wr_ev = hs_wr & ~s_reg.wr_q;
    assign h_ack_ev = hs_ack & ~s_reg.ack_q;
    assign int_rst = srst | (s_reg.rst_cnt != '0);
    assign cmd_wr_ev = h_wr_ev & (hs_addr == HOST_CMD_STAT) & ~int_rst;

    // -----------------------------------------------------------------
    // Software reset detector
    // -----------------------------------------------------------------
    hmb_swreset u_swreset (
        .clk_sys(clk_sys),
        .srst(srst),
        .cmd_valid(cmd_wr_ev),
        .cmd_low(hs_wdata[6:0]),
        .hit(swrst_hit)
    );

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.rd_q = hs_rd;
        s_next.wr_q = hs_wr;
        s_next.ack_q = hs_ack;
        if (int_rst) begin
            // Data bytes, command and vector keep their value
            s_next.cmd_empty = RST_CMD_EMPTY;
            s_next.cmd_avail = RST_CMD_AVAIL;
            s_next.din_avail = RST_DIN_AVAIL;
            s_next.dout_empty = RST_DOUT_EMPTY;
            s_next.stat_empty = RST_STAT_EMPTY;
            s_next.soft_stat = RST_SOFT_STAT;
            s_next.hint_pend = 1'b0;
            s_next.hint_en = 1'b0;
            s_next.irq_en = 1'b0;
            s_next.par_en = 1'b0;
            s_next.lirq = 1'b0;
            s_next.lrdata = RST_RDATA;
            s_next.hrdata = RST_RDATA;
            if (srst) begin
                s_next.tx_en = 1'b0;
            end
        end else begin
            // Local processor writes
            if (lreq.wr) begin
                unique case (lreq.addr)
                    LOC_CMD_STAT: begin
                        // Top two positions are ignored
                        s_next.soft_stat = lreq.wdata[ST_SOFT_HI:ST_SOFT_LO];
                        s_next.cmd_empty = lreq.wdata[ST_CMD_EMPTY];
                        s_next.stat_empty = 1'b0;
                        if (lreq.wdata[ST_CMD_EMPTY]) begin
                            s_next.cmd_avail = 1'b0;
                        end
                    end
                    LOC_DATA: begin
                        s_next.dout = lreq.wdata;
                        s_next.dout_empty = 1'b0;
                    end
                    LOC_FLAG_CTRL: begin
                        s_next.tx_en = lreq.wdata[CT_TX_EN];
                        s_next.irq_en = lreq.wdata[CT_IRQ_EN];
                        s_next.par_en = lreq.wdata[CT_PAR_EN];
                        s_next.hint_en = lreq.wdata[CT_HINT_EN];
                    end
                    LOC_VECTOR: begin
                        // Null operation while host interrupts disabled
                        if (s_reg.hint_en) begin
                            s_next.vec = lreq.wdata;
                            s_next.hint_pend = 1'b1;
                        end
                    end
                endcase
            end
            // Local processor reads
            if (lreq.inta) begin
                s_next.lrdata = LOCAL_IACK_VECTOR;
                s_next.lirq = 1'b0;
            end else if (lreq.rd) begin
                unique case (lreq.addr)
                    LOC_CMD_STAT: s_next.lrdata = s_reg.cmd;
                    LOC_DATA: begin
                        s_next.lrdata = s_reg.din;
                        s_next.din_avail = 1'b0;
                    end
                    LOC_FLAG_CTRL: begin
                        s_next.lrdata[FL_DOUT_EMPTY] = s_reg.dout_empty;
                        s_next.lrdata[FL_DIN_AVAIL] = s_reg.din_avail;
                        s_next.lrdata[FL_ONE_5] = 1'b1;
                        s_next.lrdata[FL_ONE_4] = 1'b1;
                        s_next.lrdata[FL_HINT_PEND] = s_reg.hint_pend;
                        s_next.lrdata[FL_ONE_2] = 1'b1;
                        s_next.lrdata[FL_STAT_EMPTY] = s_reg.stat_empty;
                        s_next.lrdata[FL_CMD_AVAIL] = s_reg.cmd_avail;
                    end
                    LOC_VECTOR: s_next.lrdata = UNMAPPED_RDATA;
                endcase
            end
            // Host events come last so that a host update wins over a local one
            if (h_wr_ev) begin
                if (hs_addr == HOST_CMD_STAT) begin
                    s_next.cmd = hs_wdata;
                    s_next.cmd_empty = 1'b0;
                    s_next.cmd_avail = 1'b1;
                end else begin
                    s_next.din = hs_wdata;
                    s_next.din_avail = 1'b1;
                end
            end
            if (h_rd_ev) begin
                if (hs_addr == HOST_CMD_STAT) begin
                    s_next.stat_empty = 1'b1;
                end else begin
                    s_next.dout_empty = 1'b1;
                end
            end
            if ((h_rd_ev | h_wr_ev) & s_reg.irq_en) begin
                s_next.lirq = 1'b1;
            end
            if (h_ack_ev & s_reg.hint_pend) begin
                s_next.hint_pend = 1'b0;
            end
            // Host read data shows the vector while acknowledge is high, else follows the selected port
            if (hs_ack) begin
                s_next.hrdata = s_reg.vec;
            end else if (hs_addr == HOST_CMD_STAT) begin
                s_next.hrdata[ST_DIN_EMPTY] = ~s_reg.din_avail;
                s_next.hrdata[ST_DOUT_AVAIL] = ~s_reg.dout_empty;
                s_next.hrdata[ST_SOFT_HI:ST_SOFT_LO] = s_reg.soft_stat;
                s_next.hrdata[ST_CMD_EMPTY] = s_reg.cmd_empty;
                s_next.hrdata[ST_RESET_N] = ~s_reg.core_rst;
            end else begin
                s_next.hrdata = s_reg.dout;
            end
        end
        // Internal reset line stretch after the reserved sequence
        if (srst) begin
            s_next.rst_cnt = '0;
        end else if (swrst_hit) begin
            s_next.rst_cnt = SWRST_CNT_W'(SWRST_HOLD_CYC);
        end else if (s_reg.rst_cnt != '0) begin
            s_next.rst_cnt = s_reg.rst_cnt - 1'b1;
        end
        s_next.core_rst = int_rst;
        if (int_rst) begin
            s_next.hrdata[ST_RESET_N] = 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        s_reg <= s_next;
    end

    // Outputs
    assign local_rdata = s_reg.lrdata;
    assign local_irq = s_reg.lirq;
    assign host_rdata = s_reg.hrdata;
    assign host_interrupt_line_o = 1'b0;
    assign host_interrupt_line_oe_n = ~s_reg.hint_pend;
    assign tx_enable = s_reg.tx_en;
    assign par_irq_enable = s_reg.par_en;
    assign core_reset = s_reg.core_rst;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    a_cmd_write_flags: assert property (@(posedge clk_sys) disable iff (int_rst)
        cmd_wr_ev |=> (s_reg.cmd_avail && !s_reg.cmd_empty))
        else $error("command write did not update flags");
    a_cmd_empty_set: assert property (@(posedge clk_sys) disable iff (int_rst)
        (lreq.wr && lreq.addr == LOC_CMD_STAT && lreq.wdata[ST_CMD_EMPTY] && !h_wr_ev)
        |=> (s_reg.cmd_empty && !s_reg.cmd_avail))
        else $error("command empty set did not clear available");
    a_cmd_read_keep: assert property (@(posedge clk_sys) disable iff (int_rst)
        (lreq.rd && !lreq.wr && lreq.addr == LOC_CMD_STAT && !h_wr_ev)
        |=> $stable(s_reg.cmd_avail))
        else $error("command read changed available flag");
    a_din_handshake: assert property (@(posedge clk_sys) disable iff (int_rst)
        (h_wr_ev && hs_addr == HOST_DATA) |=> (s_reg.din_avail && s_reg.din == $past(hs_wdata)))
        else $error("inbound write not flagged");
    a_dout_handshake: assert property (@(posedge clk_sys) disable iff (int_rst)
        (lreq.wr && lreq.addr == LOC_DATA && !(h_rd_ev && hs_addr == HOST_DATA))
        |=> !s_reg.dout_empty ##2 (s_reg.hrdata[ST_DOUT_AVAIL] || hs_ack
        || hs_addr != HOST_CMD_STAT || s_reg.dout_empty))
        else $error("outbound write not flagged to host");
    a_status_empty: assert property (@(posedge clk_sys) disable iff (int_rst)
        (h_rd_ev && hs_addr == HOST_CMD_STAT) |=> s_reg.stat_empty)
        else $error("status read did not set empty");
    a_local_irq: assert property (@(posedge clk_sys) disable iff (int_rst)
        ((h_rd_ev || h_wr_ev) && s_reg.irq_en) |=> local_irq)
        else $error("host access raised no local interrupt");
    a_local_iack: assert property (@(posedge clk_sys) disable iff (int_rst)
        lreq.inta |=> (local_rdata == LOCAL_IACK_VECTOR))
        else $error("local acknowledge vector wrong");
    a_vector_null: assert property (@(posedge clk_sys) disable iff (int_rst)
        (lreq.wr && lreq.addr == LOC_VECTOR && !s_reg.hint_en && !s_reg.hint_pend)
        |=> !s_reg.hint_pend)
        else $error("vector write while disabled raised request");
    a_line_pending: assert property (@(posedge clk_sys) disable iff (int_rst)
        (lreq.wr && lreq.addr == LOC_VECTOR && s_reg.hint_en && !h_ack_ev)
        |=> (!host_interrupt_line_oe_n && !host_interrupt_line_o && s_reg.hint_pend))
        else $error("vector write did not drive interrupt line");
    a_host_ack: assert property (@(posedge clk_sys) disable iff (int_rst)
        (h_ack_ev && s_reg.hint_pend && !lreq.wr) |=> (!s_reg.hint_pend
        && host_rdata == $past(s_reg.vec)))
        else $error("host acknowledge mishandled");
    a_reset_clears: assert property (@(posedge clk_sys)
        srst |=> (!tx_enable && !s_reg.hint_en && !s_reg.hint_pend && core_reset))
        else $error("reset did not clear control");
    a_flag_ones: assert property (@(posedge clk_sys) disable iff (int_rst)
        (lreq.rd && !lreq.inta && lreq.addr == LOC_FLAG_CTRL)
        |=> (local_rdata[FL_ONE_5] && local_rdata[FL_ONE_4] && local_rdata[FL_ONE_2]))
        else $error("unused flag bits not one");

endmodule
`default_nettype wire

//--- src/hmb_pkg.sv
//----------------------------------------------------------------------
// Purpose: Shared constants and types of the host mailbox interface
// Assumes: Local bus of four byte ports, host bus of two byte ports
// Notes:   Offsets, bit positions, reset values and counts live here
//----------------------------------------------------------------------
package hmb_pkg;

    // -----------------------------------------------------------------
    // Local processor port offsets
    // -----------------------------------------------------------------
    localparam logic [1:0] LOC_CMD_STAT = 2'h0; // Read command, write status
    localparam logic [1:0] LOC_DATA = 2'h1; // Read inbound, write outbound
    localparam logic [1:0] LOC_FLAG_CTRL = 2'h2; // Read flags, write control
    localparam logic [1:0] LOC_VECTOR = 2'h3; // Write host vector

    // Host port offsets
    localparam logic HOST_CMD_STAT = 1'b0; // Write command, read status
    localparam logic HOST_DATA = 1'b1; // Write inbound, read outbound

    // -----------------------------------------------------------------
    // Bit positions
    // -----------------------------------------------------------------
    localparam int ST_DIN_EMPTY = 7; // Host status fields
    localparam int ST_DOUT_AVAIL = 6;
    localparam int ST_SOFT_HI = 5;
    localparam int ST_SOFT_LO = 2;
    localparam int ST_CMD_EMPTY = 1;
    localparam int ST_RESET_N = 0;
    localparam int FL_DOUT_EMPTY = 7; // Local flag fields
    localparam int FL_DIN_AVAIL = 6;
    localparam int FL_ONE_5 = 5;
    localparam int FL_ONE_4 = 4;
    localparam int FL_HINT_PEND = 3;
    localparam int FL_ONE_2 = 2;
    localparam int FL_STAT_EMPTY = 1;
    localparam int FL_CMD_AVAIL = 0;
    localparam int CT_TX_EN = 3; // Control fields
    localparam int CT_IRQ_EN = 2;
    localparam int CT_PAR_EN = 1;
    localparam int CT_HINT_EN = 0;

    // -----------------------------------------------------------------
    // Reset values and fixed values
    // -----------------------------------------------------------------
    localparam logic RST_CMD_EMPTY = 1'b1;
    localparam logic RST_CMD_AVAIL = 1'b0;
    localparam logic RST_DIN_AVAIL = 1'b0;
    localparam logic RST_DOUT_EMPTY = 1'b1;
    localparam logic RST_STAT_EMPTY = 1'b1;
    localparam logic [3:0] RST_SOFT_STAT = 4'h0;
    localparam logic [7:0] RST_RDATA = 8'h00;
    localparam logic [7:0] LOCAL_IACK_VECTOR = 8'hFC;
    localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

    // Software reset sequence, low seven bits only
    localparam int SWRST_LEN = 6;
    localparam logic [6:0] SWRST_SEQ [SWRST_LEN] = '{7'h7E, 7'h55, 7'h0F, 7'h70, 7'h2A, 7'h7E};

    // Cycles the internal reset line stays active after a software reset
    localparam int SWRST_HOLD_CYC = 4;
    localparam int SWRST_CNT_W = 3;
    localparam int HOST_SYNC_W = 12;

    // -----------------------------------------------------------------
    // Carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic rd; // Read strobe, one cycle
        logic wr; // Write strobe, one cycle
        logic inta; // Interrupt acknowledge, one cycle
        logic [1:0] addr; // Port offset
        logic [7:0] wdata; // Write data
    } hmb_lreq_t;

    typedef struct packed {
        logic [7:0] cmd; // Command from host
        logic [7:0] din; // Inbound data byte
        logic [7:0] dout; // Outbound data byte
        logic [7:0] vec; // Vector to host
        logic [7:0] hrdata; // Host read data
        logic [7:0] lrdata; // Local read data
        logic [3:0] soft_stat; // Software status nibble
        logic cmd_empty;
        logic cmd_avail;
        logic din_avail;
        logic dout_empty;
        logic stat_empty;
        logic hint_pend;
        logic lirq;
        logic tx_en;
        logic irq_en;
        logic par_en;
        logic hint_en;
        logic rd_q;
        logic wr_q;
        logic ack_q;
        logic [SWRST_CNT_W-1:0] rst_cnt;
        logic core_rst;
    } hmb_state_t;

endpackage

//--- src/hmb_sync.sv
//----------------------------------------------------------------------
// Purpose: Two flip-flop synchroniser for a bundle of host pins
// Assumes: Each bit is a slow level relative to clk_sys
// Notes:   First stage feeds only the second stage
//----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module hmb_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic [W-1:0] d_async, // Pin levels
    output logic [W-1:0] q_sync // Synchronised levels
);

    logic [W-1:0] meta_reg;

    // -----------------------------------------------------------------
    // Two stage capture
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_reg <= '0;
            q_sync <= '0;
        end else begin
            meta_reg <= d_async;
            q_sync <= meta_reg;
        end
    end

endmodule
`default_nettype wire

//--- src/hmb_swreset.sv
//----------------------------------------------------------------------
// Purpose: Spots the reserved six byte host command sequence
// Assumes: One pulse on cmd_valid per host command write
// Notes:   Top command bit is ignored; a stray first byte restarts
//----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module hmb_swreset
    import hmb_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic cmd_valid, // Host command written, pulse
    input wire logic [6:0] cmd_low, // Low seven command bits
    output logic hit // Sequence complete, pulse
);

    typedef struct packed {
        logic [2:0] idx;
        logic hit;
    } hmb_swr_t;

    hmb_swr_t s_reg;
    hmb_swr_t s_next;

    // -----------------------------------------------------------------
    // Sequence matcher
    // -----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.hit = 1'b0;
        if (srst) begin
            s_next.idx = 3'h0;
        end else if (cmd_valid) begin
            if (cmd_low == SWRST_SEQ[s_reg.idx]) begin
                if (s_reg.idx == 3'(SWRST_LEN - 1)) begin
                    s_next.idx = 3'h0;
                    s_next.hit = 1'b1;
                end else begin
                    s_next.idx = s_reg.idx + 3'h1;
                end
            end else if (cmd_low == SWRST_SEQ[0]) begin
                s_next.idx = 3'h1;
            end else begin
                s_next.idx = 3'h0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        s_reg <= s_next;
    end

    assign hit = s_reg.hit;

endmodule
`default_nettype wire

//--- verif/hmb_host_model.sv
// Purpose: Host processor model for the mailbox host port
// Assumes: Strobes held 9 clocks high and at least 5 low
// Notes: Released write data shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module hmb_host_model (
    input wire logic clk_sys, // System clock
    output logic host_rd, // Read strobe
    output logic host_wr, // Write strobe
    output logic host_inta, // Acknowledge strobe
    output logic host_addr, // Port offset
    output logic [7:0] host_wdata, // Write data
    output logic look // Read data settled
);
    // Idle bus at time zero
    initial begin
        {host_rd, host_wr, host_inta, host_addr, host_wdata, look} = '0;
    end
    // One host cycle: 0 read, 1 write, 2 acknowledge
    task automatic cyc(input int k, input logic a, input logic [7:0] d);
        @(negedge clk_sys);
        {host_addr, host_wdata} = {a, d};
        {host_rd, host_wr, host_inta} = {k == 0, k == 1, k == 2};
        repeat (8) @(negedge clk_sys);
        look = (k != 1);
        @(negedge clk_sys);
        {look, host_rd, host_wr, host_inta} = '0;
        host_wdata = ~d;
        repeat (4) @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire

//--- verif/host_mailbox_interface_test.sv
// Purpose: Self-checking bench of the host mailbox
// Assumes: Expected bytes queued by drivers, checked by a watcher
// Notes: Signal byte packs irq, oe_n, tx, par, core reset, line drive
`timescale 1ns/1ps
`default_nettype none
module host_mailbox_interface_test;
    import hmb_pkg::*;
    logic clk_sys = 1'h0, srst = 1'h1, look_l = 1'h0, look_s = 1'h0, look;
    hmb_lreq_t lreq = '0;
    logic host_rd, host_wr, host_inta, host_addr, local_irq, host_interrupt_line_o;
    logic host_interrupt_line_oe_n, tx_enable, par_irq_enable, core_reset;
    logic [7:0] host_wdata, local_rdata, host_rdata, rnd, g;
    int fails = 0, comparisons = 0;
    logic [7:0] exp_q[$];
    wire logic line = host_interrupt_line_oe_n ? 1'h1 : host_interrupt_line_o; // Pull-up
    always #25 clk_sys = ~clk_sys;
    hmb_top hmb_top_inst (.clk_sys, .srst, .lreq, .local_rdata, .local_irq, .host_rd,
        .host_wr, .host_inta, .host_addr, .host_wdata, .host_rdata,
        .host_interrupt_line_i(line), .host_interrupt_line_o, .host_interrupt_line_oe_n,
        .tx_enable, .par_irq_enable, .core_reset);
    hmb_host_model hmb_host_model_inst (.clk_sys, .host_rd, .host_wr, .host_inta,
        .host_addr, .host_wdata, .look);
    // Watcher takes the oldest note when a result is settled
    always @(posedge clk_sys) begin
        g = look_l ? local_rdata : look ? host_rdata : {local_irq, host_interrupt_line_oe_n,
            tx_enable, par_irq_enable, core_reset, host_interrupt_line_o, 2'h0};
        if (look_l || look_s || look) begin
            comparisons++;
            if (exp_q.size() == 0 || g !== exp_q[0]) begin
                fails++;
                $display("BAD t=%0t got=%h exp=%h", $time, g, exp_q[0]);
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end
    task automatic lwr(input logic [1:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        lreq = {3'h2, a, d};
        @(negedge clk_sys);
        lreq = '0;
    endtask
    // Local read, acknowledge or signal snapshot with its expected byte
    task automatic lrd(input int k, input logic [1:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(negedge clk_sys);
        lreq = {k == 0, 1'h0, k == 1, a, 8'h00};
        @(negedge clk_sys);
        lreq = '0;
        {look_l, look_s} = {k != 2, k == 2};
        @(negedge clk_sys);
        {look_l, look_s} = '0;
    endtask
    task automatic hst(input int k, input logic a, input logic [7:0] d, input logic [7:0] e);
        if (k != 1) exp_q.push_back(e);
        hmb_host_model_inst.cyc(k, a, d);
    endtask
    task automatic final_report();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        final_report();
    end
    initial begin
        rnd = 8'($urandom(32'h10ea));
        rnd = 8'($urandom);
        repeat (12) @(negedge clk_sys);
        srst = 1'h0;
        lrd(2, 0, 8'h40);
        lrd(0, 2, 8'hB6);
        lwr(2, 8'h0E);
        hst(1, 0, rnd, 0);
        lrd(2, 0, 8'hF0);
        lrd(0, 0, rnd);
        lrd(0, 2, 8'hB7);
        lrd(1, 0, LOCAL_IACK_VECTOR);
        lrd(2, 0, 8'h70);
        $display("test command done");
        lwr(0, 8'hFF);
        lrd(0, 2, 8'hB4);
        hst(0, 0, 0, 8'hBF);
        lrd(0, 2, 8'hB6);
        hst(1, 1, 8'h5A, 0);
        hst(1, 1, 8'hA5, 0);
        lrd(0, 2, 8'hF6);
        hst(0, 0, 0, 8'h3F);
        lrd(0, 1, 8'hA5);
        lrd(0, 1, 8'hA5);
        lwr(1, 8'h3C);
        lwr(1, 8'hC3);
        lrd(0, 2, 8'h36);
        hst(0, 0, 0, 8'hFF);
        hst(0, 1, 0, 8'hC3);
        hst(0, 1, 0, 8'hC3);
        lrd(0, 2, 8'hB6);
        $display("test data done");
        lwr(3, 8'h99);
        lrd(0, 2, 8'hB6);
        lwr(2, 8'h0F);
        lwr(3, 8'h99);
        lrd(0, 2, 8'hBE);
        lwr(2, 8'h0E);
        lrd(0, 2, 8'hBE);
        hst(2, 0, 0, 8'h99);
        lrd(0, 2, 8'hB6);
        $display("test host interrupt done");
        for (int i = 0; i < SWRST_LEN; i++) hst(1, 0, {rnd[i], SWRST_SEQ[i]}, 0);
        hst(0, 0, 0, 8'h83);
        @(negedge clk_sys);
        srst = 1'h1;
        lrd(2, 0, 8'h48);
        srst = 1'h0;
        lrd(2, 0, 8'h40);
        lrd(0, 1, 8'hA5);
        lrd(0, 0, {rnd[5], 7'h7E});
        hst(0, 1, 0, 8'hC3);
        $display("test reset done");
        final_report();
    end
endmodule
`default_nettype wire
